// *** rtl/tdb_timer.v ***
`include "tdb_map.vh"

module tdb_timer (
	// Clock and reset
	input  wire        REF_CLK,
	input  wire        SRST,
	// Avalon-MM slave
	input  wire [5:0]  AVS_ADDRESS,
	input  wire        AVS_READ,
	input  wire        AVS_WRITE,
	input  wire [31:0] AVS_WRITEDATA,
	output reg  [31:0] AVS_READDATA,
	output reg         AVS_WAITREQUEST,
	// Encoder, trigger and brake inputs
	input  wire        ENC_IN1,
	input  wire        ENC_IN2,
	input  wire        BRAKE_IN,
	input  wire        CLK_FAIL,
	// Power switch pins
	output reg  [3:0]  CHAN_MAIN_OUT,
	output reg  [3:0]  CHAN_MAIN_OE,
	output reg  [2:0]  CHAN_COMPL_OUT,
	output reg  [2:0]  CHAN_COMPL_OE,
	// Event requests
	output reg         BRAKE_IRQ,
	output reg         BRAKE_DMA,
	output reg         TRIG_IRQ,
	output reg         TRIG_DMA
);
	// ======================================================================
	// Storage
	reg  [15:0] ctrl_q;
	reg  [26:0] bdt_q;
	reg  [1:0]  bk_q;
	reg  [15:0] ccer_q;
	reg  [3:0]  ien_q;
	reg  [2:0]  flag_q;
	reg  [2:0]  flag_d;
	reg  [15:0] cnt_q;
	reg  [15:0] cnt_d;
	reg  [15:0] arr_q;
	reg  [15:0] arr_act_q;
	reg  [15:0] psc_q;
	reg  [15:0] psc_act_q;
	reg  [15:0] psc_cnt_q;
	reg  [15:0] psc_cnt_d;
	reg  [15:0] cmp_q [0:3];
	reg  [3:0]  chan_ref_wave_q;
	reg  [31:0] rd_mux;
	reg         upd;
	reg         in1_s1;
	reg         in1_s2;
	reg         in2_s1;
	reg         in2_s2;
	reg         f1_q;
	reg         f2_q;
	reg  [3:0]  m_lvl;
	reg  [3:0]  m_oe;
	reg  [2:0]  c_lvl;
	reg  [2:0]  c_oe;
	reg  [1:0]  pin;
	integer     k;

	// ======================================================================
	// Decode of inputs and modes
	wire        wr_go = AVS_WRITE & ~AVS_WAITREQUEST;
	wire [2:0]  slave_mode_sel = ctrl_q[`TDB_C_SMS];
	wire [2:0]  ts = ctrl_q[`TDB_C_TS];
	wire        cen = ctrl_q[`TDB_C_CEN];
	wire        filt_in1 = in1_s2 ^ ctrl_q[`TDB_C_IN1P];
	wire        filt_in2 = in2_s2 ^ ctrl_q[`TDB_C_IN2P];
	wire        r1 = filt_in1 & ~f1_q;
	wire        r2 = filt_in2 & ~f2_q;
	wire        e1 = filt_in1 ^ f1_q;
	wire        e2 = filt_in2 ^ f2_q;
	wire        enc_mode = (slave_mode_sel == `TDB_SMS_ENC2) |
		(slave_mode_sel == `TDB_SMS_ENC1) | (slave_mode_sel == `TDB_SMS_ENC12);
	wire        cnt1 = e1 & ((slave_mode_sel == `TDB_SMS_ENC1) |
		((slave_mode_sel == `TDB_SMS_ENC12) & ~e2));
	wire        cnt2 = e2 & ((slave_mode_sel == `TDB_SMS_ENC2) |
		((slave_mode_sel == `TDB_SMS_ENC12) & ~e1));
	wire        dn1 = r1 ? filt_in2 : ~filt_in2;
	wire        dn2 = r2 ? ~filt_in1 : filt_in1;
	wire        enc_dn = cnt1 ? dn1 : dn2;
	wire        enc_step = cen & (cnt1 | cnt2);
	wire        slv_trg = (slave_mode_sel == `TDB_SMS_RESET) |
		(slave_mode_sel == `TDB_SMS_TRIG);
	wire        trg_ev = slv_trg & (((ts == `TDB_TS_IN1) & r1) |
		((ts == `TDB_TS_IN2) & r2 &
		(ctrl_q[`TDB_C_C2S] == `TDB_C2S_IN2)));
	wire        rst_ev = trg_ev & (slave_mode_sel == `TDB_SMS_RESET);
	wire        tick = cen & ~enc_mode & (psc_cnt_q == psc_act_q);
	wire        brk = bk_q[0] & ((BRAKE_IN == bk_q[1]) | CLK_FAIL);
	wire        moe_eff = bdt_q[`TDB_B_MOE] & ~brk;
	wire [3:0]  men = ccer_q[`TDB_E_MEN];
	wire [3:0]  mpol = ccer_q[`TDB_E_MPOL];
	wire [2:0]  cenb = ccer_q[`TDB_E_CEN];
	wire [2:0]  cpol = ccer_q[`TDB_E_CPOL];
	wire [3:0]  main_idle_level = bdt_q[`TDB_B_OIS];
	wire [2:0]  compl_idle_level = bdt_q[`TDB_B_COMPL_IDLE_LEVEL];
	wire [3:0]  wave_main;
	wire [2:0]  wave_compl;

	// ======================================================================
	// Pin level and enable for one output, returned as {enable, level}.
	// The inactive level of an output equals its polarity bit.
	function [1:0] pin_lvl;
		input en;
		input wave;
		input pol;
		input idle;
		input master_out_en;
		input run_offstate_sel;
		input idle_offstate_sel;
		input brake;
		begin
			if (master_out_en)
			begin
				if (en)
					pin_lvl = {1'b1, wave ^ pol};
				else
					pin_lvl = {run_offstate_sel, pol};
			end
			else if (brake && (idle != pol))
				pin_lvl = {idle_offstate_sel, pol};
			else
				pin_lvl = {idle_offstate_sel, idle};
		end
	endfunction

	// ======================================================================
	// Dead-time generators
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : dtg
			tdb_deadtime u_dt (
				.clk     (REF_CLK),
				.srst    (SRST),
				.ref_in  (chan_ref_wave_q[g]),
				.dt_on   (men[g] & cenb[g]),
				.dt_len  (bdt_q[`TDB_B_DT]),
				.main_o  (wave_main[g]),
				.compl_o (wave_compl[g])
			);
		end
	endgenerate

	assign wave_main[3] = chan_ref_wave_q[3];

	// ======================================================================
	// Output selection
	always @*
	begin
		pin = 2'h0;
		for (k = 0; k < 4; k = k + 1)
		begin
			pin = pin_lvl(men[k], wave_main[k], mpol[k], main_idle_level[k],
				moe_eff, bdt_q[`TDB_B_RUN_OFFSTATE_SEL], bdt_q[`TDB_B_IDLE_OFFSTATE_SEL], brk);
			m_oe[k] = pin[1];
			m_lvl[k] = pin[0];
		end
		for (k = 0; k < 3; k = k + 1)
		begin
			pin = pin_lvl(cenb[k], wave_compl[k], cpol[k], compl_idle_level[k],
				moe_eff, bdt_q[`TDB_B_RUN_OFFSTATE_SEL], bdt_q[`TDB_B_IDLE_OFFSTATE_SEL], brk);
			c_oe[k] = pin[1];
			c_lvl[k] = pin[0];
		end
	end

	// ======================================================================
	// Counter next state
	always @*
	begin
		cnt_d = cnt_q;
		psc_cnt_d = psc_cnt_q;
		upd = 1'b0;
		if (cen && !enc_mode)
		begin
			if (psc_cnt_q == psc_act_q)
				psc_cnt_d = `TDB_Z16;
			else
				psc_cnt_d = psc_cnt_q + `TDB_ONE16;
		end
		if (rst_ev)
		begin
			cnt_d = `TDB_Z16;
			psc_cnt_d = `TDB_Z16;
			upd = ~ctrl_q[`TDB_C_URS];
		end
		else if (enc_step && enc_dn)
		begin
			if (cnt_q == `TDB_Z16)
			begin
				cnt_d = arr_act_q;
				upd = 1'b1;
			end
			else
				cnt_d = cnt_q - `TDB_ONE16;
		end
		else if (enc_step || tick)
		begin
			// wrap to zero is the update
			if (cnt_q == arr_act_q)
			begin
				cnt_d = `TDB_Z16;
				upd = 1'b1;
			end
			else
				cnt_d = cnt_q + `TDB_ONE16;
		end
	end

	// ======================================================================
	// Flags: a hardware set wins over a clear in the same cycle.
	always @*
	begin
		flag_d = flag_q;
		if (wr_go && (AVS_ADDRESS == `TDB_A_FLAG))
			flag_d = flag_q & ~AVS_WRITEDATA[2:0];
		if (brk)
			flag_d[`TDB_F_BIF] = 1'b1;
		if (trg_ev)
			flag_d[`TDB_F_TIF] = 1'b1;
		if (upd)
			flag_d[`TDB_F_UIF] = 1'b1;
	end

	// ======================================================================
	// Read data selection
	always @*
	begin
		rd_mux = `TDB_Z32;
		if (AVS_ADDRESS == `TDB_A_CTRL)
			rd_mux[15:0] = ctrl_q;
		else if (AVS_ADDRESS == `TDB_A_BDT)
			rd_mux[26:0] = {bdt_q[26:14], bk_q, bdt_q[11:0]};
		else if (AVS_ADDRESS == `TDB_A_CCER)
			rd_mux[15:0] = ccer_q;
		else if (AVS_ADDRESS == `TDB_A_IEN)
			rd_mux[3:0] = ien_q;
		else if (AVS_ADDRESS == `TDB_A_FLAG)
			rd_mux[2:0] = flag_q;
		else if (AVS_ADDRESS == `TDB_A_CNT)
			rd_mux[15:0] = cnt_q;
		else if (AVS_ADDRESS == `TDB_A_ARR)
			rd_mux[15:0] = arr_q;
		else if (AVS_ADDRESS == `TDB_A_PSC)
			rd_mux[15:0] = psc_q;
		else if (AVS_ADDRESS == `TDB_A_CMP1)
			rd_mux[15:0] = cmp_q[0];
		else if (AVS_ADDRESS == `TDB_A_CMP2)
			rd_mux[15:0] = cmp_q[1];
		else if (AVS_ADDRESS == `TDB_A_CMP3)
			rd_mux[15:0] = cmp_q[2];
		else if (AVS_ADDRESS == `TDB_A_CMP4)
			rd_mux[15:0] = cmp_q[3];
	end

	// ======================================================================
	// Bus handshake: every access waits exactly one cycle.
	always @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA <= `TDB_Z32;
		end
		else if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST)
		begin
			AVS_WAITREQUEST <= 1'b0;
			AVS_READDATA <= rd_mux;
		end
		else
			AVS_WAITREQUEST <= 1'b1;
	end

	// ======================================================================
	// Registers, counter and resynchronisers
	always @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			ctrl_q <= `TDB_Z16;
			bdt_q <= 27'h0000000;
			bk_q <= 2'h0;
			ccer_q <= `TDB_Z16;
			ien_q <= 4'h0;
			flag_q <= 3'h0;
			cnt_q <= `TDB_Z16;
			arr_q <= `TDB_ARR_RST;
			arr_act_q <= `TDB_ARR_RST;
			psc_q <= `TDB_Z16;
			psc_act_q <= `TDB_Z16;
			psc_cnt_q <= `TDB_Z16;
			for (k = 0; k < 4; k = k + 1)
				cmp_q[k] <= `TDB_Z16;
			chan_ref_wave_q <= 4'h0;
			in1_s1 <= 1'b0;
			in1_s2 <= 1'b0;
			in2_s1 <= 1'b0;
			in2_s2 <= 1'b0;
			f1_q <= 1'b0;
			f2_q <= 1'b0;
		end
		else
		begin
			in1_s1 <= ENC_IN1;
			in1_s2 <= in1_s1;
			in2_s1 <= ENC_IN2;
			in2_s2 <= in2_s1;
			f1_q <= filt_in1;
			f2_q <= filt_in2;
			flag_q <= flag_d;
			cnt_q <= cnt_d;
			psc_cnt_q <= psc_cnt_d;
			if (upd)
			begin
				arr_act_q <= arr_q;
				psc_act_q <= psc_q;
			end
			bk_q <= bdt_q[`TDB_B_BK];
			// delay from compare, width to reload
			for (k = 0; k < 4; k = k + 1)
				chan_ref_wave_q[k] <= (cnt_q >= cmp_q[k]);
			if (wr_go)
			begin
				if (AVS_ADDRESS == `TDB_A_CTRL)
					ctrl_q <= AVS_WRITEDATA[15:0] & `TDB_C_MASK;
				else if (AVS_ADDRESS == `TDB_A_BDT)
					bdt_q <= AVS_WRITEDATA[26:0] & `TDB_B_MASK;
				else if (AVS_ADDRESS == `TDB_A_CCER)
					ccer_q <= AVS_WRITEDATA[15:0] & `TDB_E_MASK;
				else if (AVS_ADDRESS == `TDB_A_IEN)
					ien_q <= AVS_WRITEDATA[3:0];
				else if (AVS_ADDRESS == `TDB_A_CNT)
					cnt_q <= AVS_WRITEDATA[15:0];
				else if (AVS_ADDRESS == `TDB_A_ARR)
					arr_q <= AVS_WRITEDATA[15:0];
				else if (AVS_ADDRESS == `TDB_A_PSC)
					psc_q <= AVS_WRITEDATA[15:0];
				else if (AVS_ADDRESS == `TDB_A_CMP1)
					cmp_q[0] <= AVS_WRITEDATA[15:0];
				else if (AVS_ADDRESS == `TDB_A_CMP2)
					cmp_q[1] <= AVS_WRITEDATA[15:0];
				else if (AVS_ADDRESS == `TDB_A_CMP3)
					cmp_q[2] <= AVS_WRITEDATA[15:0];
				else if (AVS_ADDRESS == `TDB_A_CMP4)
					cmp_q[3] <= AVS_WRITEDATA[15:0];
			end
			// Hardware changes to the run and master bits come last so
			// that they win over a software write in the same cycle.
			// trigger starts counter
			if (trg_ev && (slave_mode_sel == `TDB_SMS_TRIG))
				ctrl_q[`TDB_C_CEN] <= 1'b1;
			else if (upd && ctrl_q[`TDB_C_OPM])
				ctrl_q[`TDB_C_CEN] <= 1'b0;
			if (brk)
				bdt_q[`TDB_B_MOE] <= 1'b0;
			else if (upd && bdt_q[`TDB_B_AOE])
				bdt_q[`TDB_B_MOE] <= 1'b1;
		end
	end

	// ======================================================================
	// Registered pins and requests
	always @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			CHAN_MAIN_OUT <= 4'h0;
			CHAN_MAIN_OE <= 4'h0;
			CHAN_COMPL_OUT <= 3'h0;
			CHAN_COMPL_OE <= 3'h0;
			BRAKE_IRQ <= 1'b0;
			BRAKE_DMA <= 1'b0;
			TRIG_IRQ <= 1'b0;
			TRIG_DMA <= 1'b0;
		end
		else
		begin
			CHAN_MAIN_OUT <= m_lvl;
			CHAN_MAIN_OE <= m_oe;
			CHAN_COMPL_OUT <= c_lvl;
			CHAN_COMPL_OE <= c_oe;
			BRAKE_IRQ <= flag_q[`TDB_F_BIF] & ien_q[`TDB_I_BIE];
			BRAKE_DMA <= flag_q[`TDB_F_BIF] & ien_q[`TDB_I_BDE];
			TRIG_IRQ <= flag_q[`TDB_F_TIF] & ien_q[`TDB_I_TIE];
			TRIG_DMA <= flag_q[`TDB_F_TIF] & ien_q[`TDB_I_TDE];
		end
	end
endmodule

// *** rtl/tdb_map.vh ***
`ifndef TDB_MAP_VH
`define TDB_MAP_VH

// ==========================================================================
// Register byte addresses
`define TDB_A_CTRL      6'h00
`define TDB_A_BDT       6'h04
`define TDB_A_CCER      6'h08
`define TDB_A_IEN       6'h0C
`define TDB_A_FLAG      6'h10
`define TDB_A_CNT       6'h14
`define TDB_A_ARR       6'h18
`define TDB_A_PSC       6'h1C
`define TDB_A_CMP1      6'h20
`define TDB_A_CMP2      6'h24
`define TDB_A_CMP3      6'h28
`define TDB_A_CMP4      6'h2C

// ==========================================================================
// Control register fields
`define TDB_C_CEN       0
`define TDB_C_URS       1
`define TDB_C_OPM       2
`define TDB_C_SMS       6:4
`define TDB_C_TS        10:8
`define TDB_C_IN1P      12
`define TDB_C_IN2P      13
`define TDB_C_C2S       15:14
`define TDB_C_MASK      16'hF777

// ==========================================================================
// Brake and dead-time register fields
`define TDB_B_DT        9:0
`define TDB_B_BKE       12
`define TDB_B_BKP       13
`define TDB_B_BK        13:12
`define TDB_B_AOE       14
`define TDB_B_MOE       15
`define TDB_B_IDLE_OFFSTATE_SEL      16
`define TDB_B_RUN_OFFSTATE_SEL      17
`define TDB_B_OIS       21:18
`define TDB_B_COMPL_IDLE_LEVEL      26:24
`define TDB_B_MASK      27'h73FF3FF

// ==========================================================================
// Channel enable and polarity fields
`define TDB_E_MEN       3:0
`define TDB_E_MPOL      7:4
`define TDB_E_CEN       10:8
`define TDB_E_CPOL      14:12
`define TDB_E_MASK      16'h77FF

// ==========================================================================
// Request enable and flag fields
`define TDB_I_BIE       0
`define TDB_I_BDE       1
`define TDB_I_TIE       2
`define TDB_I_TDE       3
`define TDB_F_BIF       0
`define TDB_F_TIF       1
`define TDB_F_UIF       2

// ==========================================================================
// Mode encodings
`define TDB_SMS_ENC2    3'h1
`define TDB_SMS_ENC1    3'h2
`define TDB_SMS_ENC12   3'h3
`define TDB_SMS_RESET   3'h4
`define TDB_SMS_TRIG    3'h6
`define TDB_TS_IN1      3'h5
`define TDB_TS_IN2      3'h6
`define TDB_C2S_IN2     2'h1

// ==========================================================================
// Widths and reset values
`define TDB_DT_W        10
`define TDB_Z16         16'h0000
`define TDB_ONE16       16'h0001
`define TDB_ARR_RST     16'hFFFF
`define TDB_Z32         32'h00000000

`endif

// *** rtl/tdb_deadtime.v ***
`include "tdb_map.vh"

// ==========================================================================
// Dead-time generator for one complementary channel
module tdb_deadtime (
	// Clock and reset
	input  wire                 clk,
	input  wire                 srst,
	// Reference and setup
	input  wire                 ref_in,
	input  wire                 dt_on,
	input  wire [`TDB_DT_W-1:0] dt_len,
	// Delayed waves
	output reg                  main_o,
	output reg                  compl_o
);
	reg                 ref_q;
	reg [`TDB_DT_W-1:0] cnt_q;
	wire                settled;

	// A reference edge restarts the count, so a pulse shorter than the
	// dead time never reaches either output.
	assign settled = (ref_in == ref_q) && (cnt_q == {`TDB_DT_W{1'b0}});

	always @(posedge clk)
	begin
		if (srst)
		begin
			ref_q   <= 1'b0;
			cnt_q   <= {`TDB_DT_W{1'b0}};
			main_o  <= 1'b0;
			compl_o <= 1'b0;
		end
		else
		begin
			ref_q <= ref_in;
			if (ref_in != ref_q)
				cnt_q <= dt_len;
			else if (cnt_q != {`TDB_DT_W{1'b0}})
				cnt_q <= cnt_q - 1'b1;
			main_o  <= ref_in & (~dt_on | settled);
			compl_o <= ~ref_in & (~dt_on | settled);
		end
	end
endmodule

// *** sim/tdb_partner.sv ***
// ==========================================================================
// Encoder, trigger source, brake source and switch pair monitor
module tdb_partner (
	// Clock
	input  wire       clk,
	// Timer inputs
	output logic      enc1,
	output logic      enc2,
	output logic      brk,
	output logic      cfail,
	// Gates of switch pairs 1 to 3
	input  wire [2:0] gate_hi,
	input  wire [2:0] gate_lo,
	output int        shoot_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ph = 2'h0;
	initial
	begin
		enc1 = 1'h0;
		enc2 = 1'h0;
		brk = 1'h0;
		cfail = 1'h0;
		shoot_cnt = 0;
	end
	// Both gates of one pair on at once would short the supply.
	always @(posedge clk)
		if (|(gate_hi & gate_lo))
			shoot_cnt <= shoot_cnt + 1;
	// Phase 1 leads phase 2 when turning forward.
	task step(input logic fwd, input int gap);
	begin
		@(posedge clk);
		ph = fwd ? ph + 2'h1 : ph - 2'h1;
		enc1 <= ph[1] ^ ph[0];
		enc2 <= ph[1];
		repeat (gap) @(posedge clk);
	end
	endtask
	task pins(input logic a, input logic b, input logic k, input logic f);
	begin
		@(posedge clk);
		enc1 <= a;
		enc2 <= b;
		brk <= k;
		cfail <= f;
	end
	endtask
endmodule

// *** sim/tdb_timer_assertions.sv ***
// ==========================================================================
// Port checker
module tdb_chk (
	// Clock and reset
	input wire        REF_CLK,
	input wire        SRST,
	// Register bus
	input wire [5:0]  AVS_ADDRESS,
	input wire        AVS_READ,
	input wire        AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire [31:0] AVS_READDATA,
	input wire        AVS_WAITREQUEST,
	// Brake and pins
	input wire        BRAKE_IN,
	input wire        CLK_FAIL,
	input wire [3:0]  CHAN_MAIN_OUT,
	input wire [3:0]  CHAN_MAIN_OE,
	input wire [2:0]  CHAN_COMPL_OUT,
	input wire [2:0]  CHAN_COMPL_OE,
	input wire        BRAKE_IRQ,
	input wire        BRAKE_DMA
);
	reg  [1:0] bkw_q;
	reg  [1:0] bk_q;
	reg  [3:0] mpol_q;
	reg  [2:0] cpol_q;
	reg  [1:0] ien_q;
	wire       wr_ack;
	wire       brk;
	assign wr_ack = AVS_WRITE && !AVS_WAITREQUEST;
	// Brake setup acts one clock after the write, so it is staged twice.
	always @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			bkw_q <= 2'h0;
			bk_q <= 2'h0;
			mpol_q <= 4'h0;
			cpol_q <= 3'h0;
			ien_q <= 2'h0;
		end
		else
		begin
			bk_q <= bkw_q;
			if (wr_ack && AVS_ADDRESS == 6'h04)
				bkw_q <= AVS_WRITEDATA[13:12];
			if (wr_ack && AVS_ADDRESS == 6'h08)
			begin
				mpol_q <= AVS_WRITEDATA[7:4];
				cpol_q <= AVS_WRITEDATA[14:12];
			end
			if (wr_ack && AVS_ADDRESS == 6'h0C)
				ien_q <= AVS_WRITEDATA[1:0];
		end
	end
	assign brk = bk_q[0] && (BRAKE_IN == bk_q[1] || CLK_FAIL);
	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (SRST);
	ack_one_a:
		assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
			|=> !AVS_WAITREQUEST) else $error("bus answer late");
	ack_pulse_a:
		assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
			else $error("bus answer held too long");
	idle_wait_a:
		assert property (!AVS_READ && !AVS_WRITE |-> AVS_WAITREQUEST)
			else $error("bus answer without request");
	unmapped_zero_a:
		assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS > 6'h2C
			|-> AVS_READDATA == 32'h0) else $error("unmapped read not 0");
	reset_state_a:
		assert property ($fell(SRST) |-> CHAN_MAIN_OE == 4'h0
			&& CHAN_COMPL_OE == 3'h0 && !BRAKE_IRQ && AVS_WAITREQUEST)
			else $error("state after reset wrong");
	brake_safe_a:
		assert property (brk |=> CHAN_MAIN_OUT == mpol_q
			&& CHAN_COMPL_OUT == cpol_q) else $error("active during brake");
	brake_irq_a:
		assert property (brk && ien_q[0] |-> ##2 BRAKE_IRQ)
			else $error("brake interrupt missing");
	brake_dma_a:
		assert property (brk && ien_q[1] |-> ##2 BRAKE_DMA)
			else $error("brake dma request missing");
	irq_mask_a:
		assert property (!ien_q[0] |=> !BRAKE_IRQ)
			else $error("masked brake interrupt raised");
endmodule
bind tdb_timer tdb_chk i_tdb_chk (
	.REF_CLK(REF_CLK),
	.SRST(SRST),
	.AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST),
	.BRAKE_IN(BRAKE_IN),
	.CLK_FAIL(CLK_FAIL),
	.CHAN_MAIN_OUT(CHAN_MAIN_OUT),
	.CHAN_MAIN_OE(CHAN_MAIN_OE),
	.CHAN_COMPL_OUT(CHAN_COMPL_OUT),
	.CHAN_COMPL_OE(CHAN_COMPL_OE),
	.BRAKE_IRQ(BRAKE_IRQ),
	.BRAKE_DMA(BRAKE_DMA)
);

// *** sim/tb_tdb_timer.sv ***
// ==========================================================================
// Timer bench
module tb_tdb_timer;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 1'h0, srst = 1'h1, rd_en = 1'h0, wr_en = 1'h0;
	logic [5:0]  addr = 6'h00;
	logic [31:0] wdata = 32'h0, rdq, rdata;
	logic        wait_q, e1, e2, bk, cf, b_irq, b_dma, t_irq, t_dma;
	logic [3:0]  m_out, m_oe;
	logic [2:0]  c_out, c_oe;
	int          fail_count = 0, cmp_count = 0, cyc = 0, k, h, l, s, dt;
	typedef struct {logic w; logic [5:0] a; logic [31:0] d, e;} tdb_row_t;
	tdb_row_t rows [9] = '{'{1'h0, 6'h00, 32'h0, 32'h0},
		'{1'h0, 6'h04, 32'h0, 32'h0}, '{1'h0, 6'h18, 32'h0, 32'hFFFF},
		'{1'h1, 6'h08, 32'hFFFFFFFF, 32'h77FF},
		'{1'h1, 6'h0C, 32'hFFFFFFFF, 32'hF},
		'{1'h1, 6'h30, 32'hFFFFFFFF, 32'h0},
		'{1'h1, 6'h20, 32'h1234ABCD, 32'hABCD},
		'{1'h1, 6'h00, 32'hFFFFFFF6, 32'hF776},
		'{1'h1, 6'h04, 32'h0FFFFFFF, 32'h73FF3FF}};
	always #12.5 ref_clk = ~ref_clk;
	tdb_timer i_tdb_timer (.REF_CLK(ref_clk), .SRST(srst),
		.AVS_ADDRESS(addr), .AVS_READ(rd_en), .AVS_WRITE(wr_en),
		.AVS_WRITEDATA(wdata), .AVS_READDATA(rdq),
		.AVS_WAITREQUEST(wait_q), .ENC_IN1(e1), .ENC_IN2(e2),
		.BRAKE_IN(bk), .CLK_FAIL(cf), .CHAN_MAIN_OUT(m_out),
		.CHAN_MAIN_OE(m_oe), .CHAN_COMPL_OUT(c_out), .CHAN_COMPL_OE(c_oe),
		.BRAKE_IRQ(b_irq), .BRAKE_DMA(b_dma), .TRIG_IRQ(t_irq),
		.TRIG_DMA(t_dma));
	tdb_partner i_tdb_partner (.clk(ref_clk), .enc1(e1), .enc2(e2),
		.brk(bk), .cfail(cf), .gate_hi(m_out[2:0]), .gate_lo(c_out),
		.shoot_cnt());
	// ======================================================================
	// Bus and check tasks
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
	begin
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_en <= w;
		rd_en <= !w;
		// The request holds until the edge that samples waitrequest low.
		@(posedge ref_clk);
		while (wait_q !== 1'h0)
			@(posedge ref_clk);
		rdata = rdq;
		wr_en <= 1'h0;
		rd_en <= 1'h0;
	end
	endtask
	task wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
	endtask
	task rd(input logic [5:0] a);
		bus(1'h0, a, 32'h0);
	endtask
	task check(input string nm, input logic [31:0] seen, exp);
	begin
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	end
	endtask
	task count_hi(input int n);
	begin
		h = 0;
		l = 0;
		repeat (n)
		begin
			@(negedge ref_clk);
			h += m_out[0];
			l += c_out[0];
		end
	end
	endtask
	task tally_and_finish;
	begin
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask
	// The whole run needs about 1600 cycles.
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 10000)
		begin
			fail_count++;
			tally_and_finish;
		end
	end
	// ======================================================================
	// Main sequence
	initial
	begin
		repeat (3) @(posedge ref_clk);
		srst <= 1'h0;
		foreach (rows[i])
		begin
			if (rows[i].w)
				wr(rows[i].a, rows[i].d);
			rd(rows[i].a);
			check("reg", rdata, rows[i].e);
		end
		wr(6'h00, 32'h0);
		wr(6'h08, 32'h0);
		wr(6'h0C, 32'h0);
		wr(6'h04, 32'h0);
		for (int m = 1; m <= 3; m++)
		begin
			k = (m == 3) ? 2 : 1;
			wr(6'h14, 32'h64);
			wr(6'h00, 32'(m * 16 + 1));
			repeat (8) i_tdb_partner.step(1'h1, 2 + m * 3);
			rd(6'h14);
			check("enc up", rdata, 32'(100 + 4 * k));
			repeat (12) i_tdb_partner.step(1'h0, 2 + m * 3);
			rd(6'h14);
			check("enc dn", rdata, 32'(100 - 2 * k));
		end
		wr(6'h18, 32'h3F);
		wr(6'h20, 32'h20);
		wr(6'h08, 32'h101);
		wr(6'h14, 32'hFFFF);
		wr(6'h00, 32'h1);
		for (int i = 0; i < 2; i++)
		begin
			dt = i ? 40 : 5;
			wr(6'h04, 32'(32'h8000 + dt));
			s = i_tdb_partner.shoot_cnt;
			repeat (150) @(posedge ref_clk);
			check("run oe", {25'h0, m_oe, c_oe}, 32'h9);
			// The gap is the dead time plus one cycle, so a 32-cycle half
			// period leaves 31 - dt active cycles.
			count_hi(128);
			check("main hi", h, dt < 31 ? 2 * (31 - dt) : 0);
			check("compl hi", l, dt < 31 ? 2 * (31 - dt) : 0);
			check("shoot", i_tdb_partner.shoot_cnt - s, 0);
		end
		wr(6'h0C, 32'h3);
		wr(6'h04, 32'hB005);
		repeat (4) @(posedge ref_clk);
		i_tdb_partner.pins(1'h0, 1'h0, 1'h1, 1'h0);
		repeat (4) @(posedge ref_clk);
		check("brk req", {30'h0, b_irq, b_dma}, 32'h3);
		rd(6'h04);
		check("moe off", {31'h0, rdata[15]}, 32'h0);
		i_tdb_partner.pins(1'h0, 1'h0, 1'h0, 1'h0);
		wr(6'h10, 32'h1);
		count_hi(64);
		check("idle", h + l, 0);
		check("idle oe", {25'h0, m_oe, c_oe}, 32'h0);
		check("irq clr", {31'h0, b_irq}, 32'h0);
		i_tdb_partner.pins(1'h0, 1'h0, 1'h0, 1'h1);
		i_tdb_partner.pins(1'h0, 1'h0, 1'h0, 1'h0);
		rd(6'h10);
		check("cfail", {31'h0, rdata[0]}, 32'h1);
		wr(6'h00, 32'h0);
		wr(6'h04, 32'hF005);
		i_tdb_partner.pins(1'h0, 1'h0, 1'h1, 1'h0);
		i_tdb_partner.pins(1'h0, 1'h0, 1'h0, 1'h0);
		rd(6'h04);
		check("aoe off", {31'h0, rdata[15]}, 32'h0);
		wr(6'h00, 32'h1);
		repeat (80) @(posedge ref_clk);
		rd(6'h04);
		check("aoe on", {31'h0, rdata[15]}, 32'h1);
		wr(6'h04, 32'h0);
		wr(6'h10, 32'h7);
		wr(6'h0C, 32'hC);
		wr(6'h14, 32'h0);
		wr(6'h00, 32'h4664);
		i_tdb_partner.pins(1'h0, 1'h1, 1'h0, 1'h0);
		repeat (8) @(posedge ref_clk);
		rd(6'h00);
		check("trig run", {31'h0, rdata[0]}, 32'h1);
		check("trig req", {30'h0, t_irq, t_dma}, 32'h3);
		repeat (80) @(posedge ref_clk);
		rd(6'h14);
		check("one pulse", rdata, 32'h0);
		rd(6'h00);
		check("stopped", {31'h0, rdata[0]}, 32'h0);
		i_tdb_partner.pins(1'h0, 1'h0, 1'h0, 1'h0);
		wr(6'h00, 32'h543);
		repeat (40) @(posedge ref_clk);
		i_tdb_partner.pins(1'h1, 1'h0, 1'h0, 1'h0);
		repeat (3) @(posedge ref_clk);
		rd(6'h14);
		check("slave rst", {31'h0, rdata < 32'h8}, 32'h1);
		tally_and_finish;
	end
endmodule
